//--- hw/flash_status_pkg.sv
/*
 * Constants, field positions and reset values for the flash status register bank.
 * Assumes one system clock; instruction decoding lives outside and delivers one-cycle events.
 */
// Contract
// - status bit 0 is high while an internal program or erase runs.
// - status bit 1 shows the write enable latch.
// - bits 2..5 hold the four-bit protection level, host read/write.
// - lock bit 7 set makes the protection level read-only.
// - busy and write enable latch are never loaded from status write data.
// - protection level, quad enable and lockdown persist as non-volatile values.
// - high byte bits 9..15 read as zero.
// - every defined status bit powers up as zero.
// - suspend flag bit 8 read-only, set by suspend, cleared by resume.
// - write enable latch clears on disable, program, erases and accepted status write.
// - protect pin low with lockdown set refuses status writes.
package flash_status_pkg;
	localparam int unsigned BUSY_POS      = 0;
	localparam int unsigned WEL_POS       = 1;
	localparam int unsigned PROT_LO_POS   = 2;
	localparam int unsigned PROT_W        = 4;
	localparam int unsigned QUAD_POS      = 6;
	localparam int unsigned LOCK_POS      = 7;
	localparam logic [7:0]  LOW_RESET     = 8'h00;
	localparam logic [7:0]  HIGH_RESET    = 8'h00;
	localparam logic [7:0]  NV_RESET      = 8'h00;
	localparam logic [7:0]  SUSPEND_OPC   = 8'h75;
	localparam logic [7:0]  RESUME_OPC    = 8'h7A;

	typedef logic [PROT_W-1:0] prot_level_t;
endpackage : flash_status_pkg

//--- hw/nv_status_cell.sv
/*
 * Non-volatile style holding cells for the writable status fields.
 * Assumes the load strobe is already qualified by lock and protect-pin checks.
 */
module nv_status_cell
	import flash_status_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	input  wire logic             nv_restore,
	input  wire logic [7:0]       nv_restore_val,
	input  wire logic             load_prot,
	input  wire logic             load_other,
	input  wire logic [7:0]       wr_val,
	output logic      [7:0]       nv_val
);
	logic [7:0] nv_ff;
	logic [7:0] nxt_nv;

	always_comb begin
		nxt_nv = nv_ff;
		if (nv_restore) begin
			nxt_nv = nv_restore_val;
		end else begin
			if (load_prot) begin
				nxt_nv[PROT_LO_POS +: PROT_W] = wr_val[PROT_LO_POS +: PROT_W];
			end
			if (load_other) begin
				nxt_nv[QUAD_POS] = wr_val[QUAD_POS];
				nxt_nv[LOCK_POS] = wr_val[LOCK_POS];
			end
		end
	end

	// reset models the erased (factory) state; real persistence is reloaded by nv_restore
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			nv_ff <= NV_RESET;
		end else begin
			nv_ff <= nxt_nv;
		end
	end

	assign nv_val = nv_ff;
endmodule : nv_status_cell

//--- hw/flash_status_bank.sv
/*
 * Status register bank of a serial flash: busy, write enable, protection, quad, lockdown, suspend.
 * Assumes an external instruction decoder on sys_clk giving one-cycle event pulses,
 * and a protect pin coming asynchronously from the package.
 */
module flash_status_bank
	import flash_status_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        wp_n_pin,
	input  wire logic        op_busy,
	input  wire logic        write_enable_instr,
	input  wire logic        write_disable_instr,
	input  wire logic        op_done_program,
	input  wire logic        op_done_erase,
	input  wire logic        opcode_valid,
	input  wire logic [7:0]  opcode,
	input  wire logic        status_write_instr,
	input  wire logic [7:0]  status_write_data,
	input  wire logic        nv_restore,
	input  wire logic [7:0]  nv_restore_val,
	output logic      [7:0]  status_low_byte,
	output logic      [7:0]  status_high_byte,
	output logic             status_write_refused,
	output logic             quad_io_enable,
	output prot_level_t      protect_level
);
	logic       wp_meta_ff;
	logic       wp_sync_ff;
	logic       busy_ff;
	logic       nxt_busy;
	logic       wel_ff;
	logic       nxt_wel;
	logic       sus_ff;
	logic       nxt_sus;
	logic       refused_ff;
	logic       nxt_refused;
	logic [7:0] nv_val;
	logic       wr_allowed;
	logic       load_prot;
	logic       load_other;

	// protect pin is asynchronous: two stages before use
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			wp_meta_ff <= 1'b1;
			wp_sync_ff <= 1'b1;
		end else begin
			wp_meta_ff <= wp_n_pin;
			wp_sync_ff <= wp_meta_ff;
		end
	end

	assign wr_allowed = status_write_instr && !(!wp_sync_ff && nv_val[LOCK_POS]);
	assign load_prot  = wr_allowed && !nv_val[LOCK_POS];
	assign load_other = wr_allowed;

	nv_status_cell u_nv (
		.sys_clk        (sys_clk),
		.rstn           (rstn),
		.nv_restore     (nv_restore),
		.nv_restore_val (nv_restore_val),
		.load_prot      (load_prot),
		.load_other     (load_other),
		.wr_val         (status_write_data),
		.nv_val         (nv_val)
	);

	always_comb begin
		nxt_busy = op_busy;
		nxt_wel  = wel_ff;
		if (write_disable_instr || op_done_program || op_done_erase || wr_allowed) begin
			nxt_wel = 1'b0;
		end else if (write_enable_instr) begin
			nxt_wel = 1'b1;
		end
		nxt_sus = sus_ff;
		if (opcode_valid && opcode == RESUME_OPC) begin
			nxt_sus = 1'b0;
		end
		if (opcode_valid && opcode == SUSPEND_OPC) begin
			nxt_sus = 1'b1;
		end
		nxt_refused = status_write_instr && !wr_allowed;
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			busy_ff    <= 1'b0;
			wel_ff     <= 1'b0;
			sus_ff     <= 1'b0;
			refused_ff <= 1'b0;
		end else begin
			busy_ff    <= nxt_busy;
			wel_ff     <= nxt_wel;
			sus_ff     <= nxt_sus;
			refused_ff <= nxt_refused;
		end
	end

	always_comb begin
		status_low_byte           = nv_val;
		status_low_byte[BUSY_POS] = busy_ff;
		status_low_byte[WEL_POS]  = wel_ff;
	end

	assign status_high_byte     = {7'h00, sus_ff};
	assign status_write_refused = refused_ff;
	assign quad_io_enable       = nv_val[QUAD_POS];
	assign protect_level        = nv_val[PROT_LO_POS +: PROT_W];
endmodule : flash_status_bank

//--- verif/flash_status_bank_monitor.sv
/* status bank port assertions; assumes one clock and a synchronous active-low reset */
module flash_status_bank_monitor import flash_status_pkg::*; (
	input logic       sys_clk,
	input logic       rstn,
	input logic       op_busy,
	input logic       opcode_valid,
	input logic [7:0] opcode,
	input logic       status_write_instr,
	input logic [7:0] status_low_byte,
	input logic [7:0] status_high_byte,
	input logic       status_write_refused);
	timeunit 1ns / 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	a_busy_shown: assert property (op_busy |=> status_low_byte[0]) else $error("busy");
	a_busy_kept: assert property (status_write_instr && !op_busy |=> !status_low_byte[0]) else $error("ro");
	a_write_clears: assert property (status_write_instr ##1 !status_write_refused |-> !status_low_byte[1])
		else $error("latch");
	a_level_lock: assert property (status_write_instr && status_low_byte[7] |=> $stable(status_low_byte[5:2]))
		else $error("lock");
	a_refuse_keep: assert property (status_write_refused |-> $stable(status_low_byte[7:2])) else $error("kept");
	a_suspend_set: assert property (opcode_valid && opcode == SUSPEND_OPC |=> status_high_byte[0])
		else $error("suspend");
	a_resume_clr: assert property (opcode_valid && opcode == RESUME_OPC |=> !status_high_byte[0])
		else $error("resume");
	a_high_zero: assert property (status_high_byte[7:1] == 7'h00) else $error("reserved");
endmodule : flash_status_bank_monitor
bind flash_status_bank flash_status_bank_monitor mon_u (.*);

//--- verif/flash_host_model.sv
/* host model issuing pulsed instructions; released data is inverted so stale values are not trusted */
module flash_host_model (
	input  logic       sys_clk,
	output logic       write_enable_instr,
	output logic       write_disable_instr,
	output logic       op_done_program,
	output logic       op_done_erase,
	output logic       opcode_valid,
	output logic [7:0] opcode,
	output logic       status_write_instr,
	output logic [7:0] status_write_data);
	timeunit 1ns / 1ns;
	initial {write_enable_instr, opcode_valid, status_write_instr, opcode, status_write_data} = '0;
	initial {write_disable_instr, op_done_program, op_done_erase} = '0;
	task automatic ins(input int k, input logic [7:0] d);
		@(posedge sys_clk);
		{write_enable_instr, opcode_valid, status_write_instr, write_disable_instr, op_done_program,
			op_done_erase} <= 6'h20 >> k;
		{opcode, status_write_data} <= {d, d};
		@(posedge sys_clk);
		{write_enable_instr, opcode_valid, status_write_instr, write_disable_instr, op_done_program,
			op_done_erase} <= 6'h00;
		{opcode, status_write_data} <= ~{d, d};
	endtask : ins
endmodule : flash_host_model

//--- verif/flash_status_bank_bench.sv
/* status bank bench; assumes 25 MHz sys_clk and synchronous active-low rstn */
module flash_status_bank_bench;
	timeunit 1ns / 1ns;
	logic sys_clk = 0, rstn = 0, wp_n_pin = 1, op_busy = 0, write_enable_instr, opcode_valid;
	logic status_write_instr, status_write_refused, write_disable_instr, op_done_program, op_done_erase;
	logic nv_restore = 0, quad_io_enable;
	logic [7:0] nv_restore_val = 8'h00;
	logic [3:0] protect_level;
	logic [7:0] opcode, status_write_data, status_low_byte, status_high_byte;
	int n_fail = 0, comparisons = 0;
	flash_host_model host_u (.*);
	flash_status_bank dut_u (.*);
	always #20 sys_clk = ~sys_clk;
	initial #100000 summarize(1);
	task automatic summarize(input int late = 0);
		n_fail += late;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	task automatic step(input int k, input logic [7:0] d, lo, hi, input logic rf = 1'b0);
		if (k < 6)
			host_u.ins(k, d);
		else
			@(posedge sys_clk);
		#1 comparisons++;
		if ({status_write_refused, quad_io_enable, protect_level, status_high_byte, status_low_byte} !==
			{rf, lo[6], lo[5:2], hi, lo}) begin
			n_fail++;
			$display("CHECK FAILED %0t %h %h", $time,
				{status_write_refused, quad_io_enable, protect_level, status_high_byte, status_low_byte},
				{rf, lo[6], lo[5:2], hi, lo});
		end
	endtask : step
	initial begin
		repeat (12) @(posedge sys_clk);
		rstn <= 1;
		step(9, 8'h00, 8'h00, 8'h00);
		step(0, 8'h00, 8'h02, 8'h00);
		step(2, 8'h3F, 8'h3C, 8'h00);
		step(2, 8'hD4, 8'hD4, 8'h00);
		step(2, 8'hBC, 8'h94, 8'h00);
		wp_n_pin <= 0;
		step(9, 8'h00, 8'h94, 8'h00);
		step(2, 8'h00, 8'h94, 8'h00, 1'b1);
		op_busy <= 1;
		step(9, 8'h00, 8'h95, 8'h00);
		op_busy <= 0;
		step(1, 8'h75, 8'h94, 8'h01);
		step(1, 8'h7A, 8'h94, 8'h00);
		step(0, 8'h00, 8'h96, 8'h00);
		step(3, 8'h00, 8'h94, 8'h00);
		step(0, 8'h00, 8'h96, 8'h00);
		step(4, 8'h00, 8'h94, 8'h00);
		step(0, 8'h00, 8'h96, 8'h00);
		step(5, 8'h00, 8'h94, 8'h00);
		step(0, 8'h00, 8'h96, 8'h00);
		step(2, 8'h00, 8'h96, 8'h00, 1'b1);
		nv_restore_val <= 8'hC3;
		nv_restore <= 1;
		step(9, 8'h00, 8'hC2, 8'h00);
		nv_restore <= 0;
		rstn <= 0;
		step(9, 8'h00, 8'h00, 8'h00);
		step(9, 8'h00, 8'h00, 8'h00);
		rstn <= 1;
		step(9, 8'h00, 8'h00, 8'h00);
		summarize();
	end
endmodule : flash_status_bank_bench
